// *** rtl/mis_core.sv ***
// Execution unit for a subset of an 8-bit instruction set.
// Assumes a sequencer hands one decoded instruction per START pulse and honours SKIP.
// Operation
// - Increment-skip-to-acc: acc gets byte plus one, skip when zero, memory kept.
// - Bit-nonzero skip: skip next when selected bit is one.
// - Conditional skips take three cycles when the skip is taken, with dummy inserted during fetch.
// - Subtract memory: acc becomes acc minus memory byte.
// - Subtract into memory: acc minus byte written to that byte.
// - Subtract immediate: acc becomes acc minus immediate constant.
// - Carry cleared on borrow, set when result zero or positive.
// - Every subtraction updates overflow, zero, half carry and carry flags.
// - Nibble exchange swaps the byte's nibbles in place, flags unchanged.
// - Nibble exchange to acc: swapped byte into acc, memory untouched.
// - Byte-zero skip: skip next when whole byte is zero.
// - Copy-then-skip: load byte into acc, skip when it is zero.
// - Bit-zero skip: skip next when selected bit is zero.
// - Current-page table read: low byte to memory, high byte to latch.
// - Last-page table read: same, word taken from the last page.
// - Exclusive-OR memory: acc gets acc xor byte, only zero flag.
// - Exclusive-OR into memory: result to byte, only zero flag.
// - Exclusive-OR immediate: acc gets acc xor immediate, only zero flag.
`include "mis_defs.svh"
module mis_core #(
    parameter int PAW = `MIS_PAW
) (
    // Clock and reset
    input wire logic CLK,
    input wire logic NRST,
    // Instruction in
    input wire logic START,
    input wire mis_pkg::mis_instr_type INSTR,
    input wire logic [`MIS_DW-1:0] TABLE_POINTER,
    // Program memory read
    output logic [PAW-1:0] PMEM_ADDR,
    output logic PMEM_RD,
    input wire logic [`MIS_PW-1:0] PMEM_DATA,
    // Status
    output logic BUSY,
    output logic DONE,
    output logic SKIP,
    output logic DUMMY,
    output logic [`MIS_DW-1:0] ACC,
    output logic [`MIS_FLAGS_W-1:0] FLAGS,
    output logic [`MIS_DW-1:0] TABLE_HIGH_LATCH,
    // Memory write echo
    output logic MEM_WE,
    output logic [`MIS_AW-1:0] MEM_WADDR,
    output logic [`MIS_DW-1:0] MEM_WDATA
);
    typedef enum logic [2:0] {IDLE, READ, EXEC, PFETCH, PWRITE, SKIPCYC} mis_fsm_type;
    mis_fsm_type state_q;
    mis_pkg::mis_instr_type ins_q;
    logic [`MIS_DW-1:0] rdata;
    logic [`MIS_DW-1:0] diff;
    logic [`MIS_FLAGS_W-1:0] sub_flags;
    logic [`MIS_DW-1:0] xor_res;
    logic [`MIS_DW-1:0] swap_res;
    logic [`MIS_DW-1:0] inc_res;
    logic [`MIS_DW-1:0] b_op;
    logic skip_d;
    logic mem_we_d;
    logic [`MIS_DW-1:0] mem_wdata_d;
    logic is_imm;
    logic [PAW-1:0] page_base;
    logic [`MIS_AW-1:0] rd_addr;
    logic is_tab;
    logic finish_d;

    assign is_imm = (ins_q.op == `MIS_OP_SUB_IMM) || (ins_q.op == `MIS_OP_XOR_IMM);
    assign b_op = is_imm ? ins_q.imm : rdata;
    assign is_tab = (ins_q.op == `MIS_OP_TAB_CUR) || (ins_q.op == `MIS_OP_TAB_LAST);
    // A refused START must not disturb the operand read of a running op
    assign rd_addr = (START && state_q == IDLE) ? INSTR.addr : ins_q.addr;
    // Last cycle of every op; taken skips and table reads run past EXEC
    assign finish_d = (state_q == PWRITE) || (state_q == SKIPCYC)
        || (state_q == EXEC && !skip_d && !is_tab);

    mis_dmem #(
        .AW(`MIS_AW),
        .DW(`MIS_DW)
    ) u_dmem (
        .clk(CLK),
        .raddr(rd_addr),
        .rdata(rdata),
        .we(mem_we_d),
        .waddr(ins_q.addr),
        .wdata(mem_wdata_d)
    );

    mis_alu u_alu (
        .a(ACC),
        .b(b_op),
        .diff(diff),
        .sub_flags(sub_flags),
        .xor_res(xor_res),
        .swap_res(swap_res),
        .inc_res(inc_res)
    );

    // Skip decision and memory write, resolved in EXEC; table reads write memory in PWRITE
    always_comb begin
        skip_d = 1'b0;
        mem_we_d = 1'b0;
        mem_wdata_d = `MIS_ZERO;
        if (state_q == EXEC) begin
            unique case (ins_q.op)
                `MIS_OP_INC_SKIP_ACC: skip_d = (inc_res == `MIS_ZERO);
                `MIS_OP_SKIP_BIT_NZ: skip_d = rdata[ins_q.bit_sel];
                `MIS_OP_SKIP_NIL: skip_d = (rdata == `MIS_ZERO);
                `MIS_OP_COPY_SKIP: skip_d = (rdata == `MIS_ZERO);
                `MIS_OP_SKIP_BIT_Z: skip_d = ~rdata[ins_q.bit_sel];
                `MIS_OP_SUB_TO_MEM: begin
                    mem_we_d = 1'b1;
                    mem_wdata_d = diff;
                end
                `MIS_OP_SWAP: begin
                    mem_we_d = 1'b1;
                    mem_wdata_d = swap_res;
                end
                `MIS_OP_XOR_TO_MEM: begin
                    mem_we_d = 1'b1;
                    mem_wdata_d = xor_res;
                end
                default: ;
            endcase
        end else if (state_q == PWRITE) begin
            mem_we_d = 1'b1;
            mem_wdata_d = PMEM_DATA[`MIS_DW-1:0];
        end
    end

    // Sequencer; reads take a cycle because memory data are registered
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            state_q <= IDLE;
            ins_q <= '0;
        end else begin
            unique case (state_q)
                IDLE: if (START) begin
                    ins_q <= INSTR;
                    state_q <= READ;
                end
                READ: state_q <= EXEC;
                EXEC: begin
                    if (is_tab) begin
                        state_q <= PFETCH;
                    end else if (skip_d) begin
                        state_q <= SKIPCYC;
                    end else begin
                        state_q <= IDLE;
                    end
                end
                PFETCH: state_q <= PWRITE;
                PWRITE: state_q <= IDLE;
                SKIPCYC: state_q <= IDLE;
                default: state_q <= IDLE;
            endcase
        end
    end

    // Accumulator
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            ACC <= `MIS_ACC_RST;
        end else if (state_q == EXEC) begin
            unique case (ins_q.op)
                `MIS_OP_INC_SKIP_ACC: ACC <= inc_res;
                `MIS_OP_SUB_MEM: ACC <= diff;
                `MIS_OP_SUB_IMM: ACC <= diff;
                `MIS_OP_SWAP_ACC: ACC <= swap_res;
                `MIS_OP_COPY_SKIP: ACC <= rdata;
                `MIS_OP_XOR_MEM: ACC <= xor_res;
                `MIS_OP_XOR_IMM: ACC <= xor_res;
                default: ;
            endcase
        end
    end

    // Status flags; swaps and skips leave them alone
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            FLAGS <= `MIS_FLAGS_RST;
        end else if (state_q == EXEC) begin
            unique case (ins_q.op)
                `MIS_OP_SUB_MEM, `MIS_OP_SUB_TO_MEM, `MIS_OP_SUB_IMM: FLAGS <= sub_flags;
                `MIS_OP_XOR_MEM, `MIS_OP_XOR_TO_MEM, `MIS_OP_XOR_IMM:
                    FLAGS[`MIS_FLAG_Z] <= (xor_res == `MIS_ZERO);
                default: ;
            endcase
        end
    end

    // Last page all ones
    // Current page is the page of the previous table read
    assign page_base = (ins_q.op == `MIS_OP_TAB_LAST)
        ? {{(PAW-`MIS_DW){1'b1}}, {`MIS_DW{1'b0}}}
        : {PMEM_ADDR[PAW-1:`MIS_DW], {`MIS_DW{1'b0}}};

    // Program memory port and table-high latch
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            PMEM_ADDR <= '0;
            PMEM_RD <= 1'b0;
            TABLE_HIGH_LATCH <= `MIS_TABLE_HIGH_LATCH_RST;
        end else begin
            PMEM_RD <= 1'b0;
            if (state_q == EXEC && is_tab) begin
                PMEM_ADDR <= page_base | {{(PAW-`MIS_DW){1'b0}}, TABLE_POINTER};
                PMEM_RD <= 1'b1;
            end
            if (state_q == PWRITE) begin
                TABLE_HIGH_LATCH <= PMEM_DATA[`MIS_PW-1:`MIS_DW];
            end
        end
    end

    // Handshake; BUSY is low exactly while idle
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            BUSY <= 1'b0;
            DONE <= 1'b0;
        end else begin
            BUSY <= (state_q == IDLE) ? START : !finish_d;
            DONE <= finish_d;
        end
    end

    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            SKIP <= 1'b0;
            DUMMY <= 1'b0;
        end else begin
            SKIP <= (state_q == EXEC) && skip_d;
            DUMMY <= (state_q == SKIPCYC);
        end
    end

    // Write echo
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            MEM_WE <= 1'b0;
            MEM_WADDR <= '0;
            MEM_WDATA <= `MIS_ZERO;
        end else begin
            MEM_WE <= mem_we_d;
            MEM_WADDR <= ins_q.addr;
            MEM_WDATA <= mem_wdata_d;
        end
    end
endmodule

// *** rtl/mis_defs.svh ***
// Constants for the instruction subset unit: opcodes, flag positions, widths.
// Included by the package and every design file; definitions only.
`ifndef MIS_DEFS_SVH
`define MIS_DEFS_SVH
`define MIS_DW 8
`define MIS_AW 8
`define MIS_PW 16
`define MIS_PAW 12
`define MIS_OP_W 5
`define MIS_OP_NOP 5'h00
`define MIS_OP_INC_SKIP_ACC 5'h01
`define MIS_OP_SKIP_BIT_NZ 5'h02
`define MIS_OP_SUB_MEM 5'h03
`define MIS_OP_SUB_TO_MEM 5'h04
`define MIS_OP_SUB_IMM 5'h05
`define MIS_OP_SWAP 5'h06
`define MIS_OP_SWAP_ACC 5'h07
`define MIS_OP_SKIP_NIL 5'h08
`define MIS_OP_COPY_SKIP 5'h09
`define MIS_OP_SKIP_BIT_Z 5'h0a
`define MIS_OP_TAB_CUR 5'h0b
`define MIS_OP_TAB_LAST 5'h0c
`define MIS_OP_XOR_MEM 5'h0d
`define MIS_OP_XOR_TO_MEM 5'h0e
`define MIS_OP_XOR_IMM 5'h0f
`define MIS_FLAG_C 0
`define MIS_FLAG_HC 1
`define MIS_FLAG_Z 2
`define MIS_FLAG_OV 3
`define MIS_FLAGS_W 4
`define MIS_NIB 4
`define MIS_ONE 8'h01
`define MIS_ZERO 8'h00
`define MIS_ACC_RST 8'h00
`define MIS_FLAGS_RST 4'h0
`define MIS_TABLE_HIGH_LATCH_RST 8'h00
`define MIS_LAST_PAGE 4'hf
`endif

// *** rtl/mis_pkg.sv ***
// Types shared by the instruction subset unit.
// Assumes mis_defs.svh is on the include path.
`include "mis_defs.svh"
package mis_pkg;
    typedef logic [`MIS_OP_W-1:0] mis_op_type;
    typedef struct packed {
        mis_op_type op;
        logic [`MIS_AW-1:0] addr;
        logic [2:0] bit_sel;
        logic [`MIS_DW-1:0] imm;
    } mis_instr_type;
    typedef struct packed {
        logic [`MIS_DW-1:0] acc;
        logic [`MIS_FLAGS_W-1:0] flags;
    } mis_state_type;
endpackage

// *** rtl/mis_alu.sv ***
// Combinational datapath: subtraction with flags, exclusive-OR, swap, increment.
// Pure function of its inputs; the caller registers all results.
`include "mis_defs.svh"
module mis_alu (
    // Operands
    input wire logic [`MIS_DW-1:0] a,
    input wire logic [`MIS_DW-1:0] b,
    // Results
    output logic [`MIS_DW-1:0] diff,
    output logic [`MIS_FLAGS_W-1:0] sub_flags,
    output logic [`MIS_DW-1:0] xor_res,
    output logic [`MIS_DW-1:0] swap_res,
    output logic [`MIS_DW-1:0] inc_res
);
    logic [`MIS_DW:0] wide;
    logic [`MIS_NIB:0] low;
    always_comb begin
        wide = {1'b0, a} - {1'b0, b};
        low = {1'b0, a[`MIS_NIB-1:0]} - {1'b0, b[`MIS_NIB-1:0]};
        diff = wide[`MIS_DW-1:0];
        sub_flags[`MIS_FLAG_C] = ~wide[`MIS_DW];
        sub_flags[`MIS_FLAG_HC] = ~low[`MIS_NIB];
        sub_flags[`MIS_FLAG_OV] = (a[`MIS_DW-1] ^ b[`MIS_DW-1])
            & (a[`MIS_DW-1] ^ wide[`MIS_DW-1]);
        sub_flags[`MIS_FLAG_Z] = (wide[`MIS_DW-1:0] == `MIS_ZERO);
        xor_res = a ^ b;
        swap_res = {b[`MIS_NIB-1:0], b[`MIS_DW-1:`MIS_NIB]};
        inc_res = b + `MIS_ONE;
    end
endmodule

// *** rtl/mis_dmem.sv ***
// Small data memory: one write port, one read port with registered read data.
// Read data appear the cycle after the address is presented.
`include "mis_defs.svh"
module mis_dmem #(
    parameter int AW = `MIS_AW,
    parameter int DW = `MIS_DW
) (
    // Clock
    input wire logic clk,
    // Read port
    input wire logic [AW-1:0] raddr,
    output logic [DW-1:0] rdata,
    // Write port
    input wire logic we,
    input wire logic [AW-1:0] waddr,
    input wire logic [DW-1:0] wdata
);
    logic [DW-1:0] mem [0:(1<<AW)-1];
    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end
    always_ff @(posedge clk) begin
        rdata <= mem[raddr];
    end
endmodule

// *** verif/mis_core_sva.sv ***
// Concurrent checks on the ports of the instruction subset unit.
// Assumes mis_pkg and mis_defs.svh are compiled first; bound to mis_core.
`include "mis_defs.svh"
module mis_core_sva #(
    parameter int PAW = `MIS_PAW
) (
    // Clock and reset
    input wire logic CLK,
    input wire logic NRST,
    // Request
    input wire logic START,
    input wire mis_pkg::mis_instr_type INSTR,
    // Results
    input wire logic [PAW-1:0] PMEM_ADDR,
    input wire logic PMEM_RD,
    input wire logic BUSY,
    input wire logic DONE,
    input wire logic SKIP,
    input wire logic DUMMY,
    input wire logic [`MIS_DW-1:0] ACC,
    input wire logic [`MIS_FLAGS_W-1:0] FLAGS,
    input wire logic MEM_WE
);
    logic take;
    mis_pkg::mis_op_type op_q;
    // BUSY is low exactly while the unit is idle, DONE cycle included
    assign take = START && !BUSY;
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            op_q <= 5'h00;
        end else if (take) begin
            op_q <= INSTR.op;
        end
    end
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!NRST);
    AST_TAB_LAT: assert property (
        take && INSTR.op inside {5'h0b, 5'h0c} |-> ##3 PMEM_RD ##2 DONE)
        else $error("table read timing wrong");
    AST_LAST_PAGE: assert property (
        PMEM_RD && op_q == 5'h0c |-> PMEM_ADDR[PAW-1 -: 4] == 4'hf)
        else $error("last page not addressed");
    AST_SKIP_LAT: assert property (
        take && INSTR.op inside {5'h01, 5'h02, 5'h08, 5'h09, 5'h0a} |-> ##3 (DONE ^ SKIP))
        else $error("skip op timing wrong");
    AST_SKIP_DUMMY: assert property (SKIP |=> DUMMY && DONE)
        else $error("dummy cycle missing");
    AST_DUMMY_CAUSE: assert property (DUMMY |-> $past(SKIP))
        else $error("dummy without skip");
    AST_SUB_FLAGS: assert property (
        DONE && op_q inside {5'h03, 5'h05}
        |-> FLAGS[0] == (ACC <= $past(ACC)) && FLAGS[2] == (ACC == 8'h00))
        else $error("subtract carry or zero wrong");
    AST_XOR_FLAGS: assert property (
        DONE && op_q inside {5'h0d, 5'h0e, 5'h0f}
        |-> (FLAGS & 4'hb) == ($past(FLAGS) & 4'hb))
        else $error("xor touched other flags");
    AST_SWAP_FLAGS: assert property (
        DONE && op_q inside {5'h06, 5'h07} |-> $stable(FLAGS))
        else $error("swap changed flags");
    AST_NO_WRITE: assert property (
        DONE && op_q inside {5'h01, 5'h03, 5'h05, 5'h07, 5'h09} |-> !MEM_WE)
        else $error("unexpected memory write");
    AST_COPY_SKIP: assert property (
        DONE && op_q inside {5'h01, 5'h09} |-> (ACC == 8'h00) == $past(SKIP))
        else $error("skip disagrees with acc");
    AST_BUSY_SET: assert property (take |=> BUSY)
        else $error("busy not raised after start");
    AST_BUSY_DONE: assert property (DONE |-> !BUSY)
        else $error("busy still high at done");
    cover property (SKIP ##1 DUMMY);
    cover property (PMEM_RD && op_q == 5'h0c);
    cover property (DONE && op_q == 5'h04);
endmodule
bind mis_core mis_core_sva #(.PAW(PAW)) u_sva (.CLK(CLK), .NRST(NRST), .START(START),
    .INSTR(INSTR), .PMEM_ADDR(PMEM_ADDR), .PMEM_RD(PMEM_RD), .BUSY(BUSY), .DONE(DONE),
    .SKIP(SKIP), .DUMMY(DUMMY), .ACC(ACC), .FLAGS(FLAGS), .MEM_WE(MEM_WE));

// *** verif/testbench.sv ***
// Self-checking bench for the instruction subset unit.
// Assumes mis_pkg and mis_defs.svh are compiled first.
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk;
    logic nrst = 1'b0;
    logic start = 1'b0;
    mis_pkg::mis_instr_type ins = '0;
    logic [7:0] tp = 8'h00;
    logic [15:0] pd = 16'h0000;
    logic [11:0] pa;
    logic prd, busy, done, skip, dmy, we, sk, dm, w;
    logic [7:0] acc, tbh, wa, wd, ea, ed;
    logic [3:0] fl;
    int miscompares = 0;
    int checks = 0;
    int n;
    mis_core u_dut (.CLK(clk), .NRST(nrst), .START(start), .INSTR(ins),
        .TABLE_POINTER(tp), .PMEM_ADDR(pa), .PMEM_RD(prd), .PMEM_DATA(pd),
        .BUSY(busy), .DONE(done), .SKIP(skip), .DUMMY(dmy), .ACC(acc), .FLAGS(fl),
        .TABLE_HIGH_LATCH(tbh), .MEM_WE(we), .MEM_WADDR(wa), .MEM_WDATA(wd));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic end_sim;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic chk(input string s, input logic [23:0] e, input logic [23:0] g);
        checks++;
        if (g !== e) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", s, e, g);
        end
    endtask
    // Echo pulses are latched so one pass sees the whole op
    task automatic run(input logic [4:0] op, input logic [7:0] a, input logic [2:0] b,
            input logic [7:0] x);
        @(posedge clk);
        start <= 1'b1;
        ins <= {op, a, b, x};
        @(posedge clk);
        start <= 1'b0;
        sk = 1'b0;
        dm = 1'b0;
        w = 1'b0;
        for (n = 1; n <= 9; n++) begin
            @(posedge clk);
            #1;
            sk |= skip;
            dm |= dmy;
            if (we === 1'b1) begin
                w = 1'b1;
                ea = wa;
                ed = wd;
            end
            if (done === 1'b1) break;
        end
        if (n > 9) begin
            chk("done wait", 24'h1, 24'h0);
            end_sim();
        end
    endtask
    task automatic ld(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk);
        pd <= {8'h5a, v};
        run(5'h0c, a, 3'h0, 8'h00);
    endtask
    task automatic seta(input logic [7:0] v);
        ld(8'hff, v);
        run(5'h09, 8'hff, 3'h0, 8'h00);
    endtask
    function automatic logic [3:0] ef(input logic [7:0] a, input logic [7:0] b);
        logic [7:0] d;
        d = a - b;
        return {(a[7] != b[7]) && (d[7] != a[7]), d == 8'h00, a[3:0] >= b[3:0], a >= b};
    endfunction
    task automatic t_table;
        logic [4:0] ops[3] = '{5'h0b, 5'h0c, 5'h0b};
        logic [3:0] pg[3] = '{4'h0, 4'hf, 4'hf};
        for (int i = 0; i < 3; i++) begin
            @(posedge clk);
            tp <= 8'h3c + 8'(i);
            pd <= {8'ha0 + 8'(i), 8'h21 + 8'(i)};
            run(ops[i], 8'h10 + 8'(i), 3'h0, 8'h00);
            chk("paddr", {pg[i], 8'h3c + 8'(i)}, pa);
            chk("latch", 8'ha0 + 8'(i), tbh);
            chk("mem", {8'h10 + 8'(i), 8'h21 + 8'(i)}, {ea, ed});
        end
        run(5'h09, 8'h12, 3'h0, 8'h00);
        chk("readback", 8'h23, acc);
    endtask
    task automatic t_sub;
        logic [7:0] av[5] = '{8'h05, 8'h03, 8'h44, 8'h80, 8'h10};
        logic [7:0] bv[5] = '{8'h03, 8'h05, 8'h44, 8'h01, 8'h01};
        logic [7:0] d;
        for (int i = 0; i < 5; i++) begin
            for (int k = 3; k <= 5; k++) begin
                d = av[i] - bv[i];
                seta(av[i]);
                ld(8'h20, bv[i]);
                run(5'(k), 8'h20, 3'h0, bv[i]);
                chk("sub flags", ef(av[i], bv[i]), fl);
                if (k == 4) begin
                    chk("minus_into_memory", {8'h20, d, av[i]}, {ea, ed, acc});
                end else begin
                    chk("sub acc", d, acc);
                end
            end
        end
    endtask
    task automatic t_xor;
        seta(8'h80);
        run(5'h05, 8'h00, 3'h0, 8'h01);
        ld(8'h30, 8'h7f);
        run(5'h0d, 8'h30, 3'h0, 8'h00);
        chk("xor", {4'hd, 8'h00}, {fl, acc});
        run(5'h0e, 8'h30, 3'h0, 8'h00);
        chk("exclusive_or_into_memory", {8'h30, 8'h7f, 4'h9}, {ea, ed, fl});
        run(5'h0f, 8'h00, 3'h0, 8'h3c);
        chk("xori", {4'h9, 8'h3c}, {fl, acc});
    endtask
    task automatic t_swap;
        ld(8'h40, 8'h9c);
        run(5'h06, 8'h40, 3'h0, 8'h00);
        chk("swap", {4'h9, 8'h40, 8'hc9}, {fl, ea, ed});
        run(5'h07, 8'h40, 3'h0, 8'h00);
        chk("nibble_exchange_to_acc", {4'h9, 1'b0, 8'h9c}, {fl, w, acc});
    endtask
    task automatic t_skip;
        logic [4:0] op[10] = '{5'h01, 5'h01, 5'h02, 5'h02, 5'h08, 5'h08, 5'h09, 5'h09, 5'h0a, 5'h0a};
        logic [7:0] m[10] = '{8'hff, 8'h7f, 8'h08, 8'hf7, 8'h00, 8'h01, 8'h00, 8'h5a, 8'hef, 8'h10};
        logic [2:0] b[10] = '{3'h0, 3'h0, 3'h3, 3'h3, 3'h0, 3'h0, 3'h0, 3'h0, 3'h4, 3'h4};
        logic s;
        for (int i = 0; i < 10; i++) begin
            s = ~i[0];
            ld(8'h50, m[i]);
            run(op[i], 8'h50, b[i], 8'h00);
            // DONE shows two edges after the START edge, one more with a skip
            chk("skip", {s, s, 1'b0, 4'h2 + 4'(s)}, {sk, dm, w, 4'(n)});
            if (op[i] == 5'h01) chk("inc acc", 8'(m[i] + 8'h01), acc);
            if (op[i] == 5'h09) chk("copy acc", m[i], acc);
        end
    endtask
    initial begin
        repeat (20) @(posedge clk);
        nrst <= 1'b1;
        t_table();
        t_sub();
        t_xor();
        t_swap();
        t_skip();
        end_sim();
    end
endmodule
